// ### pkg/umls_pkg.sv
// Purpose: constants for the modem control / line status / modem status block
// Assumes: AXI4-Lite slave, 32-bit data, one register per aligned word
package umls_pkg;
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFF_DATA     = 8'h00;  // write: holding reg, read: receive reg
  localparam logic [7:0]  OFF_MCTRL    = 8'h04;
  localparam logic [7:0]  OFF_LSTAT    = 8'h08;
  localparam logic [7:0]  OFF_MSTAT    = 8'h0c;
  localparam logic [7:0]  OFF_CONFIG   = 8'h10;
  // modem_control fields
  localparam int          MC_DTR       = 0;
  localparam int          MC_RTS       = 1;
  localparam int          MC_SEL       = 2;
  localparam int          MC_IMM       = 3;
  localparam int          MC_LOOP      = 4;
  // config fields
  localparam int          CF_FIFO      = 0;
  localparam int          CF_LSIE      = 2;
  localparam int          CF_MSIE      = 3;
  localparam int          CF_TXDIS     = 4;
  localparam int          CF_AUTO      = 6;
  localparam logic [7:0]  MCTRL_RESET  = 8'h00;
  localparam logic [7:0]  CONFIG_RESET = 8'h00;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;
endpackage : umls_pkg

// ### design/umls_top.sv
// Purpose: per-channel modem control, line status and modem status logic
// Assumes: serial shifters live outside; they hand over characters as strobes
// Notes: modem pins and rx line are asynchronous and pass two flip-flops
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module umls_top #(
  parameter int DEPTH   = 64,  // fifo depth
  parameter int FLOW_HI = 56   // receive level that deasserts the flow pin
) (
  input  wire logic                      clk,            // 100 MHz
  input  wire logic                      rst_n,          // async, active low
  input  wire logic [umls_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input  wire logic                      s_axi_awvalid,  // write address valid
  output logic                           s_axi_awready,  // write address ready
  input  wire logic [31:0]               s_axi_wdata,    // write data
  input  wire logic [3:0]                s_axi_wstrb,    // byte enables
  input  wire logic                      s_axi_wvalid,   // write data valid
  output logic                           s_axi_wready,   // write data ready
  output logic [1:0]                     s_axi_bresp,    // write response
  output logic                           s_axi_bvalid,   // write response valid
  input  wire logic                      s_axi_bready,   // write response ready
  input  wire logic [umls_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input  wire logic                      s_axi_arvalid,  // read address valid
  output logic                           s_axi_arready,  // read address ready
  output logic [31:0]                    s_axi_rdata,    // read data
  output logic [1:0]                     s_axi_rresp,    // read response
  output logic                           s_axi_rvalid,   // read data valid
  input  wire logic                      s_axi_rready,   // read data ready
  output logic                           txValid,        // character offered to shifter
  output logic [7:0]                     txData,         // character
  input  wire logic                      txReady,        // shifter takes it
  input  wire logic                      txShiftBusy,    // shifter holds a character
  input  wire logic                      swFlowPending,  // xon/xoff waiting to go out
  input  wire logic                      rxValid,        // received character strobe
  input  wire logic [7:0]                rxData,         // received character
  input  wire logic                      rxParityErr,    // with rxValid
  input  wire logic                      rxFrameErr,     // with rxValid
  input  wire logic                      rxBreak,        // line low for a full frame
  input  wire logic                      rxLine,         // raw receive pin
  input  wire logic                      ctsN,           // clear-to-send pin
  input  wire logic                      dsrN,           // set-ready pin
  input  wire logic                      carrierDetectN, // carrier detect pin
  input  wire logic                      ringIndicatorN, // ring indicator pin
  output logic                           rtsN,           // request-to-send pin
  output logic                           dtrN,           // terminal-ready pin
  output logic                           lineStatusIrq,  // line status interrupt
  output logic                           modemStatusIrq  // modem status interrupt
);
  import umls_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW:0] HI_CNT   = (AW+1)'(FLOW_HI);

  function automatic logic [AW-1:0] ptrInc(input logic [AW-1:0] p);
    ptrInc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : ptrInc

  logic rstSync1, rstSync2, rstN;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end
  assign rstN = rstSync2;

  // pins: first stage read only by the second
  logic [4:0] pinMeta, pinSync;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pinMeta <= 5'h1f;
      pinSync <= 5'h1f;
    end else begin
      pinMeta <= {rxLine, ringIndicatorN, carrierDetectN, dsrN, ctsN};
      pinSync <= pinMeta;
    end
  end

  logic [7:0] modemCtrl, cfgReg;
  logic       loopOn;
  assign loopOn = modemCtrl[MC_LOOP];

  // ---------------- AXI4-Lite slave ----------------
  logic                awHeld, wHeld;
  logic [ADDR_W-1:0]   awAddr;
  logic [31:0]         wData;
  logic                wByte0;
  logic                doWrite, doRead;
  logic [ADDR_W-1:0]   rAddr;
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign doRead  = s_axi_arvalid && s_axi_arready;
  assign rAddr   = s_axi_araddr;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= '0;
      wData  <= '0;
      wByte0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld  <= 1'b1;
        wData  <= s_axi_wdata;
        wByte0 <= s_axi_wstrb[0];
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  logic wrData, wrMctrl, wrConfig, wrMapped;
  assign wrData   = doWrite && wByte0 && awAddr == OFF_DATA;
  assign wrMctrl  = doWrite && wByte0 && awAddr == OFF_MCTRL;
  assign wrConfig = doWrite && wByte0 && awAddr == OFF_CONFIG;
  assign wrMapped = awAddr == OFF_DATA || awAddr == OFF_MCTRL || awAddr == OFF_CONFIG;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------- receive fifo ----------------
  logic [10:0]   rxMem [DEPTH];  // {break, framing, parity, data}
  logic [AW-1:0] rxWr, rxRd;
  logic [AW:0]   rxCount, errCount;
  logic          rxFull, rxPush, rxPop, breakActive, overrun;
  logic [10:0]   rxIn, rxTop;
  assign rxFull = cfgReg[CF_FIFO] ? (rxCount == FULL_CNT) : (rxCount != '0);
  // a break pushes once per low period
  assign rxIn   = rxBreak ? 11'h400 : {1'b0, rxFrameErr, rxParityErr, rxData};
  assign rxPush = ((rxValid && !rxBreak) || (rxBreak && !breakActive)) && !rxFull;
  assign rxPop  = doRead && rAddr == OFF_DATA && rxCount != '0;
  assign rxTop  = rxMem[rxRd];

  always_ff @(posedge clk) begin
    if (rxPush) begin
      rxMem[rxWr] <= rxIn;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rxWr     <= '0;
      rxRd     <= '0;
      rxCount  <= '0;
      errCount <= '0;
    end else begin
      if (rxPush) begin
        rxWr <= ptrInc(rxWr);
      end
      if (rxPop) begin
        rxRd <= ptrInc(rxRd);
      end
      rxCount  <= rxCount + (AW+1)'(rxPush) - (AW+1)'(rxPop);
      errCount <= errCount + (AW+1)'(rxPush && |rxIn[10:8])
                           - (AW+1)'(rxPop && |rxTop[10:8]);
    end
  end

  // set wins over the clear in both flags
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      breakActive <= 1'b0;
      overrun     <= 1'b0;
    end else begin
      if (rxBreak) begin
        breakActive <= 1'b1;
      end else if (pinSync[4]) begin
        breakActive <= 1'b0;
      end
      if ((rxValid || rxBreak) && rxFull) begin
        overrun <= 1'b1;
      end else if (doRead && rAddr == OFF_LSTAT) begin
        overrun <= 1'b0;
      end
    end
  end

  // ---------------- transmit path ----------------
  logic [7:0]    txMem [DEPTH];
  logic [AW-1:0] txWr, txRd;
  logic [AW:0]   txCount;
  logic          txFull, txPush, txPop, immPending, immTake, flowStop;
  logic [7:0]    immByte;
  assign immTake = wrData && modemCtrl[MC_IMM] && !loopOn && !cfgReg[CF_TXDIS];
  assign txFull  = cfgReg[CF_FIFO] ? (txCount == FULL_CNT) : (txCount != '0);
  assign txPush  = wrData && !immTake && !txFull;
  // dsr pair selected: a high set-ready holds back the next character
  assign flowStop = cfgReg[CF_AUTO] &&
                    (modemCtrl[MC_SEL] ? pinSync[1] : pinSync[0]);
  assign txValid = !flowStop && !cfgReg[CF_TXDIS] && !swFlowPending &&
                   (immPending || txCount != '0);
  assign txData  = immPending ? immByte : txMem[txRd];
  assign txPop   = txValid && txReady && !immPending;

  always_ff @(posedge clk) begin
    if (txPush) begin
      txMem[txWr] <= wData[7:0];
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      txWr       <= '0;
      txRd       <= '0;
      txCount    <= '0;
      immPending <= 1'b0;
      immByte    <= 8'h00;
    end else begin
      if (txPush) begin
        txWr <= ptrInc(txWr);
      end
      if (txPop) begin
        txRd <= ptrInc(txRd);
      end
      txCount <= txCount + (AW+1)'(txPush) - (AW+1)'(txPop);
      if (immTake) begin
        immPending <= 1'b1;
        immByte    <= wData[7:0];
      end else if (txValid && txReady) begin
        immPending <= 1'b0;
      end
    end
  end

  // ---------------- control registers ----------------
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      modemCtrl <= MCTRL_RESET;
      cfgReg    <= CONFIG_RESET;
    end else begin
      if (wrMctrl) begin
        modemCtrl <= {3'b000, wData[4:0]};
      end else if (immTake) begin
        modemCtrl[MC_IMM] <= 1'b0;
      end
      if (wrConfig) begin
        cfgReg <= wData[7:0] & 8'h5d;
      end
    end
  end

  // pins are active low; auto flow takes the selected output
  logic autoRts, autoDtr, flowHold;
  assign flowHold = rxCount >= HI_CNT;
  assign autoRts  = cfgReg[CF_AUTO] && !modemCtrl[MC_SEL];
  assign autoDtr  = cfgReg[CF_AUTO] && modemCtrl[MC_SEL];
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rtsN <= 1'b1;
      dtrN <= 1'b1;
    end else begin
      rtsN <= loopOn || (autoRts ? flowHold : !modemCtrl[MC_RTS]);
      dtrN <= loopOn || (autoDtr ? flowHold : !modemCtrl[MC_DTR]);
    end
  end

  // ---------------- modem status ----------------
  logic [3:0] modemNow, modemLast, delta;  // {cd, ri, dsr, cts}
  assign modemNow = loopOn ?
      {modemCtrl[MC_IMM], modemCtrl[MC_SEL], modemCtrl[MC_DTR], modemCtrl[MC_RTS]} :
      ~{pinSync[2], pinSync[3], pinSync[1], pinSync[0]};
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      modemLast <= 4'h0;
      delta     <= 4'h0;
    end else begin
      modemLast <= modemNow;
      for (int i = 0; i < 4; i++) begin
        if (modemNow[i] != modemLast[i]) begin
          delta[i] <= 1'b1;
        end else if (doRead && rAddr == OFF_MSTAT) begin
          delta[i] <= 1'b0;
        end
      end
    end
  end

  logic [7:0] lineStat, modemStat;
  assign lineStat = {errCount != '0,
                     txCount == '0 && !immPending && !txShiftBusy,
                     txCount == '0 && !immPending,
                     breakActive || (rxCount != '0 && rxTop[10]),
                     rxCount != '0 && rxTop[9],
                     rxCount != '0 && rxTop[8],
                     overrun,
                     rxCount != '0};
  assign modemStat = {modemNow[3], modemNow[2], modemNow[1], modemNow[0],
                      delta[3], delta[2], delta[1], delta[0]};

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      lineStatusIrq  <= 1'b0;
      modemStatusIrq <= 1'b0;
    end else begin
      lineStatusIrq  <= cfgReg[CF_LSIE] && (errCount != '0 || overrun);
      modemStatusIrq <= cfgReg[CF_MSIE] && |delta;
    end
  end

  // read data is captured at the address handshake so side effects match it
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (doRead) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      case (rAddr)
        OFF_DATA:   s_axi_rdata <= {24'h0, rxCount != '0 ? rxTop[7:0] : 8'h00};
        OFF_MCTRL:  s_axi_rdata <= {24'h0, modemCtrl};
        OFF_LSTAT:  s_axi_rdata <= {24'h0, lineStat};
        OFF_MSTAT:  s_axi_rdata <= {24'h0, modemStat};
        OFF_CONFIG: s_axi_rdata <= {24'h0, cfgReg};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- checks ----------------
  imm_clears_a: assert property (@(posedge clk) disable iff (!rstN)
      immTake |=> !modemCtrl[MC_IMM] && immPending) else $error("immediate bit kept");
  imm_first_a: assert property (@(posedge clk) disable iff (!rstN)
      immTake |=> txData == $past(wData[7:0])) else $error("queued byte first");
  imm_txdis_a: assert property (@(posedge clk) disable iff (!rstN)
      wrData && cfgReg[CF_TXDIS] |=> !immPending || $past(immPending))
      else $error("immediate while disabled");
  dsr_stop_a: assert property (@(posedge clk) disable iff (!rstN)
      cfgReg[CF_AUTO] && modemCtrl[MC_SEL] && pinSync[1] |-> !txValid)
      else $error("sent while set-ready high");
  rts_pin_a: assert property (@(posedge clk) disable iff (!rstN)
      !loopOn && !cfgReg[CF_AUTO] |=> rtsN == !$past(modemCtrl[MC_RTS]))
      else $error("rts pin wrong");
  dtr_pin_a: assert property (@(posedge clk) disable iff (!rstN)
      !loopOn && !cfgReg[CF_AUTO] |=> dtrN == !$past(modemCtrl[MC_DTR]))
      else $error("dtr pin wrong");
  overrun_keep_a: assert property (@(posedge clk) disable iff (!rstN)
      rxValid && rxFull && !rxPop |=> overrun && $stable(rxCount))
      else $error("overrun mishandled");
  ready_flag_a: assert property (@(posedge clk) disable iff (!rstN)
      lineStat[0] == (rxCount != '0) && (!lineStat[7] || lineStat[0]))
      else $error("data ready wrong");
  temt_flag_a: assert property (@(posedge clk) disable iff (!rstN)
      lineStat[6] |-> lineStat[5] && !txShiftBusy) else $error("empty flag wrong");
  loop_cd_a: assert property (@(posedge clk) disable iff (!rstN)
      loopOn |-> modemStat[7] == modemCtrl[MC_IMM] && modemStat[6] == modemCtrl[MC_SEL])
      else $error("loopback status wrong");
  delta_read_a: assert property (@(posedge clk) disable iff (!rstN)
      doRead && rAddr == OFF_MSTAT && modemNow == modemLast |=> delta == 4'h0)
      else $error("delta not cleared");
  brk_once_a: assert property (@(posedge clk) disable iff (!rstN)
      breakActive && rxBreak |-> !rxPush) else $error("second break char");

  imm_sent_c: cover property (@(posedge clk) disable iff (!rstN) immPending && txValid && txReady);
  overrun_c:  cover property (@(posedge clk) disable iff (!rstN) rxValid && rxFull);
  delta_c:    cover property (@(posedge clk) disable iff (!rstN) modemStatusIrq);
  flow_c:     cover property (@(posedge clk) disable iff (!rstN) flowStop && txCount != '0);
endmodule : umls_top
`default_nettype wire

// ### tb/umls_link_model.sv
// Purpose: far-side transmit shifter for the modem/line status block
// Assumes: one character occupies the shifter for four clocks
// Notes: stall holds the shifter off so that characters queue up
`timescale 1ns/10ps
`default_nettype none
module umls_link_model (
  input  wire logic       clk,         // core clock
  input  wire logic       rst_n,       // async, active low
  input  wire logic       stall,       // hold off the shifter
  input  wire logic       txValid,     // character offered
  input  wire logic [7:0] txData,      // character
  output logic            txReady,     // shifter free
  output logic            txShiftBusy, // shifter holds a character
  output logic            gotValid,    // one pulse per character
  output logic [7:0]      gotData      // character taken
);
  logic [2:0] busyCnt;
  // ready only when idle, so a character never lands on a busy shifter
  assign txShiftBusy = busyCnt != 3'h0;
  assign txReady     = !txShiftBusy && !stall;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busyCnt  <= 3'h0;
      gotValid <= 1'b0;
      gotData  <= 8'h00;
    end else if (txValid && txReady) begin
      busyCnt  <= 3'h4;
      gotValid <= 1'b1;
      gotData  <= txData;
    end else begin
      gotValid <= 1'b0;
      if (busyCnt != 3'h0) begin
        busyCnt <= busyCnt - 3'h1;
      end
    end
  end
endmodule : umls_link_model
`default_nettype wire

// ### tb/umls_top_test.sv
// Purpose: self-checking bench for the modem/line status block
// Assumes: fifo depth 4, flow level 2
// Notes: register access goes through the axi-lite tasks only
`timescale 1ns/10ps
`default_nettype none
module umls_top_test;
  import umls_pkg::*;
  logic clk, rst_n, awValid, wValid, bReady, arValid, rReady;
  logic awReady, wReady, bValid, arReady, rValid, txValid, txReady, busy;
  logic stall, gotV, rxValid, pe, fe, rxBreak, rxLine, dsrN, rtsN, dtrN;
  logic lsIrq, msIrq, ctsN, swFlow;
  logic [7:0]  awAddr, arAddr, txData, got, rxData;
  logic [31:0] wData, rData;
  logic [1:0]  bResp, rResp;
  logic [7:0]  seen[$];
  int          n_mismatch, checks, cyc;
  umls_top #(.DEPTH(4), .FLOW_HI(2)) u_umls_top (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .txValid(txValid), .txData(txData), .txReady(txReady), .txShiftBusy(busy),
    .swFlowPending(swFlow), .rxValid(rxValid), .rxData(rxData), .rxParityErr(pe),
    .rxFrameErr(fe), .rxBreak(rxBreak), .rxLine(rxLine), .ctsN(ctsN),
    .dsrN(dsrN), .carrierDetectN(1'b1), .ringIndicatorN(1'b1), .rtsN(rtsN),
    .dtrN(dtrN), .lineStatusIrq(lsIrq), .modemStatusIrq(msIrq));
  umls_link_model u_umls_link_model (
    .clk(clk), .rst_n(rst_n), .stall(stall), .txValid(txValid),
    .txData(txData), .txReady(txReady), .txShiftBusy(busy),
    .gotValid(gotV), .gotData(got));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (gotV) seen.push_back(got);
    cyc++;
    // far more than the whole sequence needs
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : ck
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    awAddr  <= a;
    wData   <= {24'h0, d};
    awValid <= 1'b1;
    wValid  <= 1'b1;
    bReady  <= 1'b1;
    forever begin
      @(posedge clk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
      if (bValid) break;
    end
    bReady <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    arAddr  <= a;
    arValid <= 1'b1;
    rReady  <= 1'b1;
    forever begin
      @(posedge clk);
      if (arReady) arValid <= 1'b0;
      if (rValid) break;
    end
    d = rData;
    r = rResp;
    rReady <= 1'b0;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    ck(n, e, d);
  endtask : rdc
  task automatic rxc(input logic [7:0] d, input logic p, input logic f, input logic b);
    @(posedge clk);
    rxValid <= !b;
    rxBreak <= b;
    rxData  <= d;
    pe      <= p;
    fe      <= f;
    @(posedge clk);
    rxValid <= 1'b0;
    rxBreak <= 1'b0;
  endtask : rxc
  task automatic t_pins();
    rdc(OFF_MCTRL, 32'h0, "mctrl reset");
    rdc(OFF_LSTAT, 32'h60, "lstat reset");
    ck("pins idle", 2'b11, {rtsN, dtrN});
    wr(OFF_MCTRL, 8'h03);
    repeat (2) @(posedge clk);
    ck("pins on", 2'b00, {rtsN, dtrN});
    rdc(OFF_MCTRL, 32'h03, "mctrl rw");
    wr(OFF_MCTRL, 8'h1d);
    repeat (5) @(posedge clk);
    rdc(OFF_MSTAT, 32'hee, "loop status");
    ck("loop pins", 2'b11, {rtsN, dtrN});
    wr(OFF_MCTRL, 8'h00);
  endtask : t_pins
  task automatic t_rx();
    wr(OFF_CONFIG, 8'h05);
    rxc(8'h11, 1'b1, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    ck("line irq", 1'b1, lsIrq);
    rdc(OFF_LSTAT, 32'he5, "parity");
    rdc(OFF_DATA, 32'h11, "rx par");
    rdc(OFF_LSTAT, 32'h60, "par clear");
    rxc(8'h22, 1'b0, 1'b1, 1'b0);
    rdc(OFF_LSTAT, 32'he9, "framing");
    rdc(OFF_DATA, 32'h22, "rx frm");
    rxLine <= 1'b0;
    rxc(8'h00, 1'b0, 1'b0, 1'b1);
    rdc(OFF_LSTAT, 32'hf1, "break");
    rxLine <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(OFF_DATA, 32'h00, "rx brk");
    rdc(OFF_LSTAT, 32'h60, "brk clear");
    for (int i = 1; i < 6; i++) rxc(8'(i), 1'b0, 1'b0, 1'b0);
    rdc(OFF_LSTAT, 32'h63, "overrun");
    for (int i = 1; i < 5; i++) rdc(OFF_DATA, i, "rx kept");
    rdc(OFF_LSTAT, 32'h60, "rx empty");
  endtask : t_rx
  task automatic t_imm();
    stall <= 1'b1;
    wr(OFF_CONFIG, 8'h01);
    wr(OFF_DATA, 8'ha1);
    wr(OFF_DATA, 8'ha2);
    wr(OFF_MCTRL, 8'h08);
    wr(OFF_DATA, 8'h55);
    rdc(OFF_LSTAT, 32'h00, "tx busy");
    rdc(OFF_MCTRL, 32'h00, "imm self clr");
    stall <= 1'b0;
    for (int i = 0; i < 200 && seen.size() < 3; i++) @(posedge clk);
    ck("tx first", 8'h55, seen[0]);
    ck("tx next", 16'ha1a2, {seen[1], seen[2]});
    repeat (10) @(posedge clk);
    rdc(OFF_LSTAT, 32'h60, "tx idle");
  endtask : t_imm
  task automatic t_modem();
    logic [31:0] d;
    logic [1:0]  r;
    wr(OFF_CONFIG, 8'h08);
    rd(OFF_MSTAT, d, r);
    dsrN <= 1'b0;
    repeat (6) @(posedge clk);
    ck("modem irq", 1'b1, msIrq);
    rdc(OFF_MSTAT, 32'h22, "dsr delta");
    rdc(OFF_MSTAT, 32'h20, "delta clr");
    rd(8'h20, d, r);
    ck("unmapped", RESP_SLVERR, r);
  endtask : t_modem
  task automatic t_flow();
    seen.delete();
    wr(OFF_CONFIG, 8'h41);
    wr(OFF_MCTRL, 8'h04);
    dsrN <= 1'b1;
    repeat (5) @(posedge clk);
    wr(OFF_DATA, 8'h3c);
    repeat (10) @(posedge clk);
    ck("flow stop", 0, seen.size());
    dsrN <= 1'b0;
    for (int i = 0; i < 50 && seen.size() < 1; i++) @(posedge clk);
    ck("flow go", 8'h3c, seen[0]);
  endtask : t_flow
  task automatic t_hold();
    seen.delete();
    wr(OFF_MCTRL, 8'h00);
    wr(OFF_DATA, 8'h5a);
    repeat (10) @(posedge clk);
    ck("cts stop", 0, seen.size());
    ck("auto pins", 2'b01, {rtsN, dtrN});
    rxc(8'h01, 1'b0, 1'b0, 1'b0);
    rxc(8'h02, 1'b0, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    ck("rts hold", 1'b1, rtsN);
    rdc(OFF_DATA, 32'h01, "hold rx1");
    rdc(OFF_DATA, 32'h02, "hold rx2");
    ctsN <= 1'b0;
    for (int i = 0; i < 50 && seen.size() < 1; i++) @(posedge clk);
    ck("cts go", 8'h5a, seen[0]);
    wr(OFF_CONFIG, 8'h11);
    wr(OFF_MCTRL, 8'h08);
    wr(OFF_DATA, 8'h77);
    rdc(OFF_MCTRL, 32'h08, "imm kept");
    wr(OFF_MCTRL, 8'h00);
    swFlow <= 1'b1;
    wr(OFF_CONFIG, 8'h01);
    repeat (10) @(posedge clk);
    ck("xon first", 1, seen.size());
    swFlow <= 1'b0;
    for (int i = 0; i < 50 && seen.size() < 2; i++) @(posedge clk);
    ck("txdis fifo", 8'h77, seen[1]);
  endtask : t_hold
  initial begin
    rst_n   = 1'b0;
    {awValid, wValid, bReady, arValid, rReady, stall, swFlow} = '0;
    {rxValid, pe, fe, rxBreak} = '0;
    {rxLine, dsrN, ctsN} = 3'b111;
    {awAddr, arAddr, rxData} = '0;
    wData   = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_pins();
    t_rx();
    t_imm();
    t_modem();
    t_flow();
    t_hold();
    report_and_stop();
  end
endmodule : umls_top_test
`default_nettype wire
